// ==== prts_sequencer.sv ====
// Power transition reset sequencer: power-on delay, reset pin, low-supply reset.
// Assumes i_sys_clk is the oscillator clock; supply comparators and the pin
// are asynchronous; the option store answers a read with a data valid pulse.
// Overview of operation
// - After the oscillator starts, internal reset stays on for 4064 cycles, then releases.
// - The power-on delay length is a parameter, 4064 by default or 4096 for the other family.
// - After the delay expires, reset remains while the external low-active pin is held low.
// - While any internal reset source is present, the device drives the shared reset pin low.
// - Low-supply reset sets below the inhibit threshold and clears above recovery, or whenever the latched enable is off.
// - A low-supply reset counts whether from the internal detector or an outside supervisor.
// - While low-supply reset is asserted the delay counter is cleared and held, restarting after.
// - On variants with the option, oscillator start is inhibited during low-supply reset.
// - Option bits are read at power-up and re-read periodically during operation.
// - Each option value read is copied into a latch whose output drives the controlled logic.
// - Low-supply resets take effect only when the latched enable option allows them.
// - The option enable is not in effect until clocks run and the first read completes.
`timescale 1ns/1ps
`include "prts_regs.svh"
module prts_sequencer #(
    parameter int unsigned POR_CYCLES    = `PRTS_POR_CYCLES_A,
    parameter int unsigned REFRESH_CYC   = `PRTS_OPT_REFRESH_CYC,
    parameter int unsigned OPT_READ_CYC  = `PRTS_OPT_READ_CYC,
    parameter bit          OSC_INHIBIT   = 1'b1
) (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_reset,
    // Reset pin, open drain
    input  wire logic i_rst_pin_n,
    output logic      o_rst_pin_n,
    output logic      o_rst_pin_oe_n,
    // Supply comparators
    input  wire logic i_below_supply_inhibit_threshold,
    input  wire logic i_above_supply_recovery_threshold,
    // Option bits store
    output logic      o_option_bits_store_rd,
    input  wire logic i_option_bits_store_valid,
    input  wire logic i_option_bits_store_lvr_en,
    // Status
    output logic      o_internal_reset,
    output logic      o_low_supply_reset,
    output logic      o_osc_enable,
    output logic      o_option_valid
);
    localparam int CW = $clog2(POR_CYCLES + 1);
    localparam int RW = $clog2(REFRESH_CYC + OPT_READ_CYC + 1);

    // Synchronised pins
    logic pin_n_s;
    logic below_s;
    logic above_s;

    prts_sync #(.RESET_VAL(1'b1)) u_pin (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_async   (i_rst_pin_n),
        .o_level   (pin_n_s)
    );
    prts_sync #(.RESET_VAL(1'b0)) u_below (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_async   (i_below_supply_inhibit_threshold),
        .o_level   (below_s)
    );
    prts_sync #(.RESET_VAL(1'b0)) u_above (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_async   (i_above_supply_recovery_threshold),
        .o_level   (above_s)
    );

    // Option read sequencer
    prts_pkg::prts_opt_state_t opt_state_r;
    prts_pkg::prts_opt_state_t opt_state_nxt;
    logic [RW-1:0]             opt_cnt_r;
    logic [RW-1:0]             opt_cnt_nxt;
    logic                      opt_rd_r;
    logic                      lvr_en_latch_r;
    logic                      opt_valid_r;
    wire                       opt_take = (opt_state_r == prts_pkg::PRTS_OPT_READ)
                                          && i_option_bits_store_valid;
    wire                       opt_timeout = (opt_state_r == prts_pkg::PRTS_OPT_READ)
                                             && (opt_cnt_r == RW'(OPT_READ_CYC));

    always_comb begin
        opt_state_nxt = opt_state_r;
        opt_cnt_nxt   = opt_cnt_r + RW'(1);
        unique case (opt_state_r)
            prts_pkg::PRTS_OPT_IDLE: begin
                opt_state_nxt = prts_pkg::PRTS_OPT_READ;
                opt_cnt_nxt   = '0;
            end
            prts_pkg::PRTS_OPT_READ: begin
                if (opt_take || opt_timeout) begin
                    opt_state_nxt = prts_pkg::PRTS_OPT_WAIT;
                    opt_cnt_nxt   = '0;
                end
            end
            prts_pkg::PRTS_OPT_WAIT: begin
                if (opt_cnt_r == RW'(REFRESH_CYC - 1)) begin
                    opt_state_nxt = prts_pkg::PRTS_OPT_READ;
                    opt_cnt_nxt   = '0;
                end
            end
            default: begin
                opt_state_nxt = prts_pkg::PRTS_OPT_IDLE;
                opt_cnt_nxt   = '0;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            opt_state_r <= prts_pkg::PRTS_OPT_IDLE;
            opt_cnt_r   <= '0;
            opt_rd_r    <= 1'b0;
        end else begin
            opt_state_r <= opt_state_nxt;
            opt_cnt_r   <= opt_cnt_nxt;
            opt_rd_r    <= (opt_state_nxt == prts_pkg::PRTS_OPT_READ);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            lvr_en_latch_r <= `PRTS_LVR_EN_DEFAULT;
            opt_valid_r    <= 1'b0;
        end else if (opt_take) begin
            lvr_en_latch_r <= i_option_bits_store_lvr_en;
            opt_valid_r    <= 1'b1;
        end
    end

    // Low-supply reset with hysteresis
    logic lsr_r;
    wire  lvr_active = opt_valid_r && lvr_en_latch_r;
    wire  lsr_set    = below_s;
    wire  lsr_clr    = above_s && !below_s;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            lsr_r <= 1'b0;
        end else if (!lvr_active) begin
            lsr_r <= 1'b0;
        end else if (lsr_set) begin
            lsr_r <= 1'b1;
        end else if (lsr_clr) begin
            lsr_r <= 1'b0;
        end
    end

    // Power-on delay counter
    logic [CW-1:0] por_cnt_r;
    wire           por_done = (por_cnt_r == CW'(POR_CYCLES));
    wire           osc_en   = !(OSC_INHIBIT && lsr_r);

    always_ff @(posedge i_sys_clk) begin
        if (i_reset || lsr_r) begin
            por_cnt_r <= '0;
        end else if (!por_done && osc_en) begin
            por_cnt_r <= por_cnt_r + CW'(1);
        end
    end

    // Reset combination and pin drive
    wire  pin_low   = !pin_n_s;
    wire  own_reset = !por_done || lsr_r;
    wire  int_rst   = own_reset || pin_low;
    logic int_rst_r;
    logic drive_r;
    logic osc_en_r;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            int_rst_r <= 1'b1;
            drive_r   <= 1'b1;
            osc_en_r  <= 1'b1;
        end else begin
            int_rst_r <= int_rst;
            drive_r   <= own_reset;
            osc_en_r  <= osc_en;
        end
    end

    assign o_rst_pin_n            = 1'b0;
    assign o_rst_pin_oe_n         = !drive_r;
    assign o_internal_reset       = int_rst_r;
    assign o_low_supply_reset     = lsr_r;
    assign o_osc_enable           = osc_en_r;
    assign o_option_valid         = opt_valid_r;
    assign o_option_bits_store_rd = opt_rd_r;
endmodule : prts_sequencer

// ==== prts_regs.svh ====
// Timing counts and reset values for the power transition reset sequencer.
// Assumes inclusion by bare name from the sequencer design files.
`ifndef PRTS_REGS_SVH
`define PRTS_REGS_SVH
`define PRTS_POR_CYCLES_A      4064
`define PRTS_POR_CYCLES_B      4096
`define PRTS_OPT_REFRESH_CYC   1024
`define PRTS_OPT_READ_CYC      4
`define PRTS_LVR_EN_DEFAULT    1'b0
`endif

// ==== prts_pkg.sv ====
// Types for the power transition reset sequencer.
// Assumes no other package.
package prts_pkg;
    typedef enum logic [1:0] {
        PRTS_OPT_IDLE = 2'b00,
        PRTS_OPT_READ = 2'b01,
        PRTS_OPT_WAIT = 2'b10
    } prts_opt_state_t;
endpackage : prts_pkg

// ==== prts_sync.sv ====
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes the input is asynchronous to i_sys_clk.
`timescale 1ns/1ps
module prts_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_reset,
    // Pin in, filtered level out
    input  wire logic i_async,
    output logic      o_level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;
    wire  agree = (s2_r == s3_r);

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            s1_r  <= RESET_VAL;
            s2_r  <= RESET_VAL;
            s3_r  <= RESET_VAL;
            lvl_r <= RESET_VAL;
        end else begin
            s1_r <= i_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (agree) begin
                lvl_r <= s3_r;
            end
        end
    end

    assign o_level = lvl_r;
endmodule : prts_sync

// ==== prts_monitor.sv ====
// Port checker for the reset sequencer.
// Assumes a bind to every prts_sequencer instance.
`timescale 1ns/1ps
module prts_monitor #(
    parameter int unsigned POR_CYCLES = 16
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Watched ports
    input wire logic i_rst_pin_n,
    input wire logic i_option_bits_store_valid,
    input wire logic o_rst_pin_n,
    input wire logic o_option_bits_store_rd,
    input wire logic o_internal_reset,
    input wire logic o_low_supply_reset,
    input wire logic o_osc_enable,
    input wire logic o_option_valid
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    logic [15:0] quiet_r;
    // Cycles since reset or low supply last seen
    always_ff @(posedge i_sys_clk) begin
        if (i_reset || o_low_supply_reset) quiet_r <= 16'h0000;
        else if (quiet_r != 16'hFFFF) quiet_r <= quiet_r + 16'h0001;
    end
    sequence pin_held_s;
        !i_rst_pin_n [*8];
    endsequence
    a_pin_data_low: assert property (o_rst_pin_n == 1'b0)
        else $error("pin data not low");
    a_pin_hold: assert property (pin_held_s |-> o_internal_reset)
        else $error("pin low without reset");
    a_por_count: assert property ($fell(o_internal_reset) |-> quiet_r >= POR_CYCLES)
        else $error("reset released early");
    a_lsr_reset: assert property (o_low_supply_reset |-> ##[0:1] o_internal_reset)
        else $error("low supply without reset");
    a_osc_hold: assert property (o_low_supply_reset |-> ##[0:1] !o_osc_enable)
        else $error("oscillator not held");
    a_lsr_gate: assert property (o_low_supply_reset |-> o_option_valid)
        else $error("low supply before option");
    a_rd_bound: assert property ($rose(o_option_bits_store_rd) |-> ##[1:6] !o_option_bits_store_rd)
        else $error("read never ends");
    a_opt_latch: assert property ($rose(o_option_valid) |-> $past(i_option_bits_store_valid))
        else $error("option valid without data");
endmodule : prts_monitor
bind prts_sequencer prts_monitor #(.POR_CYCLES(POR_CYCLES)) u_mon (
    .i_sys_clk, .i_reset, .i_rst_pin_n, .i_option_bits_store_valid, .o_rst_pin_n,
    .o_option_bits_store_rd, .o_internal_reset, .o_low_supply_reset, .o_osc_enable,
    .o_option_valid);

// ==== prts_board_model.sv ====
// Board side: option store answer and the pulled-up shared reset pin.
// Assumes the sequencer drives the pin open drain with a low enable.
`timescale 1ns/1ps
module prts_board_model (
    // Clock
    input  wire logic i_sys_clk,
    // Sequencer side
    input  wire logic i_rd,
    input  wire logic i_oe_n,
    output logic      o_valid,
    output logic      o_lvr_en,
    output logic      o_pin_n,
    // Bench controls
    input  wire logic i_ext_low,
    input  wire logic i_en
);
    logic [1:0] cnt_r = 2'h0;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rd) cnt_r <= 2'h0;
        else if (cnt_r != 2'h3) cnt_r <= cnt_r + 2'h1;
    end
    assign o_valid  = (cnt_r == 2'h2);
    assign o_lvr_en = o_valid ? i_en : ~i_en;
    assign o_pin_n  = ~(i_ext_low | ~i_oe_n);
endmodule : prts_board_model

// ==== tb_top.sv ====
// Self-checking bench for the reset sequencer with short counts.
// Assumes the board model and the bound checker.
`timescale 1ns/1ps
module tb_top;
    localparam int POR = 16;
    typedef struct { logic en; logic lsr; } prts_row_t;
    prts_row_t rows [3] = '{'{1'b0, 1'b0}, '{1'b1, 1'b1}, '{1'b0, 1'b0}};
    logic i_sys_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_below_supply_inhibit_threshold = 1'b0;
    logic i_above_supply_recovery_threshold = 1'b1;
    logic ext_low = 1'b0;
    logic opt_en = 1'b0;
    logic i_rst_pin_n, i_option_bits_store_valid, i_option_bits_store_lvr_en;
    logic o_rst_pin_n, o_rst_pin_oe_n, o_option_bits_store_rd;
    logic o_internal_reset, o_low_supply_reset, o_osc_enable, o_option_valid;
    wire [2:0] mon = {o_option_valid, o_low_supply_reset, o_internal_reset};
    int fail_count = 0;
    int check_count = 0;
    int n;
    always #10 i_sys_clk = ~i_sys_clk;
    prts_sequencer #(.POR_CYCLES(POR), .REFRESH_CYC(32), .OPT_READ_CYC(4),
        .OSC_INHIBIT(1'b1)) u_dut (.i_sys_clk, .i_reset, .i_rst_pin_n, .o_rst_pin_n,
        .o_rst_pin_oe_n, .i_below_supply_inhibit_threshold,
        .i_above_supply_recovery_threshold, .o_option_bits_store_rd,
        .i_option_bits_store_valid, .i_option_bits_store_lvr_en, .o_internal_reset,
        .o_low_supply_reset, .o_osc_enable, .o_option_valid);
    prts_board_model u_board (.i_sys_clk, .i_rd(o_option_bits_store_rd),
        .i_oe_n(o_rst_pin_oe_n), .o_valid(i_option_bits_store_valid),
        .o_lvr_en(i_option_bits_store_lvr_en), .o_pin_n(i_rst_pin_n),
        .i_ext_low(ext_low), .i_en(opt_en));
    task automatic check(input bit ok, input string msg);
        check_count++;
        if (!ok) begin
            fail_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    task automatic wait_for(input int k, input logic v, input int lim);
        n = 0;
        while (mon[k] !== v && n < lim) begin
            @(negedge i_sys_clk);
            n++;
        end
        if (mon[k] !== v) begin
            check(1'b0, "wait ran out");
            summarize();
        end
    endtask : wait_for
    initial begin
        repeat (4) @(negedge i_sys_clk);
        check(o_internal_reset === 1'b1 && o_option_valid === 1'b0, "reset");
        check(o_rst_pin_oe_n === 1'b0 && o_rst_pin_n === 1'b0, "pin not driven");
        i_reset = 1'b0;
        repeat (POR) @(negedge i_sys_clk);
        check(o_internal_reset === 1'b1, "early release");
        wait_for(0, 1'b0, 40);
        check(o_option_valid === 1'b1, "no option read");
        $display("test power-on done");
        ext_low = 1'b1;
        repeat (20) @(negedge i_sys_clk);
        check(o_internal_reset === 1'b1 && o_rst_pin_oe_n === 1'b1, "pin");
        ext_low = 1'b0;
        wait_for(0, 1'b0, 40);
        check(n < 10, "counter restarted by pin");
        $display("test pin done");
        foreach (rows[i]) begin
            opt_en = rows[i].en;
            repeat (40) @(negedge i_sys_clk);
            i_below_supply_inhibit_threshold = 1'b1;
            i_above_supply_recovery_threshold = 1'b0;
            repeat (8) @(negedge i_sys_clk);
            check(mon[1:0] === {2{rows[i].lsr}} && o_osc_enable === ~rows[i].lsr, "set");
            i_below_supply_inhibit_threshold = 1'b0;
            repeat (8) @(negedge i_sys_clk);
            check(o_low_supply_reset === rows[i].lsr, "hysteresis");
            i_above_supply_recovery_threshold = 1'b1;
            wait_for(0, 1'b0, 60);
            check(n >= POR || !rows[i].lsr, "delay not restarted");
            $display("test row %0d done", i);
        end
        summarize();
    end
endmodule : tb_top
